// ---- shared/kbc_host_pkg.sv ----
// Constants for the keyboard controller host interface
package kbc_host_pkg;
	// Host I/O addresses
	localparam logic [7:0] HOST_DATA_ADDR   = 8'h60;
	localparam logic [7:0] HOST_STATUS_ADDR = 8'h64;
	localparam logic [7:0] FAST_A20_ADDR    = 8'h92;
	localparam int         ADDR_CMD_BIT     = 2;
	// Status register fields
	localparam int         STAT_OBF_BIT     = 0;
	localparam int         STAT_IBF_BIT     = 1;
	localparam int         STAT_CMD_BIT     = 3;
	localparam logic [7:0] STAT_USER_MASK   = 8'hf4;
	localparam logic [7:0] STATUS_RESET     = 8'h00;
	// Controller port 2 bit positions
	localparam int         P2_A20_BIT       = 1;
	localparam int         P2_AUX_DATA_BIT  = 2;
	localparam int         P2_AUX_CLK_BIT   = 3;
	localparam int         P2_KBD_INTERRUPT_OUT_BIT      = 4;
	localparam int         P2_MIRQ_BIT      = 5;
	localparam int         P2_KBD_CLK_BIT   = 6;
	localparam int         P2_KBD_DATA_BIT  = 7;
	localparam logic [7:0] PORT2_RESET      = 8'h00;
	// Fast gate port
	localparam int         FAST_CFG_EN_BIT  = 2;
	localparam logic [7:0] FAST_A20_RESET   = 8'h24;
	localparam logic [7:0] FAST_A20_WMASK   = 8'h03;
	localparam int         FAST_GATE_BIT    = 1;
	// Memories
	localparam int         ROM_BYTES        = 2048;
	localparam int         RAM_BYTES        = 256;
	// Clocking and reset
	localparam int         SYS_CLK_KHZ      = 50000;
	localparam int         CTRL_CLK_KHZ     = 12000;
	localparam int         RESET_MIN_PERIODS = 24;
	localparam logic [4:0] RESET_COUNT      = 5'(RESET_MIN_PERIODS);
endpackage

// ---- hw/frac_tick_gen.sv ----
// Fractional clock-enable generator
module frac_tick_gen #(
	parameter int NUM = 12000,
	parameter int DEN = 50000
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_reset,
	input  wire logic i_clk_en,
	// Tick out
	output logic      o_tick
);
	localparam int W = $clog2(DEN) + 1;
	localparam logic [W-1:0] STEP = W'(NUM);
	localparam logic [W-1:0] WRAP = W'(DEN);

	logic [W-1:0] acc;
	logic [W-1:0] next_acc;

	// Phase accumulator keeps the average rate exact, with some jitter
	always_comb begin
		next_acc = acc + STEP;
		if (next_acc >= WRAP) begin
			next_acc = next_acc - WRAP;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			acc    <= '0;
			o_tick <= 1'b0;
		end else if (i_clk_en) begin
			acc    <= next_acc;
			o_tick <= (acc + STEP) >= WRAP;
		end
	end
endmodule // frac_tick_gen

// ---- hw/kbc_host_interface.sv ----
// Keyboard controller host port, status, pins and power modes
module kbc_host_interface
	import kbc_host_pkg::*;
#(
	parameter int ROM_DEPTH = ROM_BYTES,
	parameter int RAM_DEPTH = RAM_BYTES
) (
	// Clock and reset
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_RESET,
	input  wire logic        I_CLK_EN,
	// Host I/O port
	input  wire logic [7:0]  I_HOST_ADDR,
	input  wire logic        I_HOST_RD,
	input  wire logic        I_HOST_WR,
	input  wire logic [7:0]  I_HOST_WDATA,
	output logic [7:0]       O_HOST_RDATA,
	output logic             O_HOST_RVALID,
	input  wire logic [7:0]  I_FAST_GATE_CONFIG,
	// Host interrupts and gate
	output logic             O_KBD_INTERRUPT_OUT,
	output logic             O_AUX_INTERRUPT_OUT,
	output logic             O_A20_GATE,
	output logic             O_ALTERNATE_GATE_OUT,
	// Controller data and status access
	input  wire logic        I_CTRL_DATA_WR,
	input  wire logic        I_CTRL_DATA_RD,
	input  wire logic [7:0]  I_CTRL_WDATA,
	input  wire logic        I_CTRL_STATUS_WR,
	input  wire logic        I_CTRL_PORT2_WR,
	input  wire logic        I_CTRL_EN_FLAGS,
	input  wire logic        I_CTRL_IBF_IE,
	output logic [7:0]       O_CTRL_INPUT_PORT,
	output logic [7:0]       O_CTRL_STATUS,
	output logic [7:0]       O_CTRL_PORT2,
	output logic [1:0]       O_CTRL_PORT1_SENSE,
	output logic [1:0]       O_CTRL_TEST_SENSE,
	output logic             O_CTRL_INPUT_FULL_INTERRUPT,
	// Controller power and clocking
	input  wire logic        I_CTRL_HALT,
	input  wire logic        I_CTRL_STOP,
	output logic             O_CTRL_RESET,
	output logic             O_CTRL_ALU_TICK,
	output logic             O_CTRL_TIMER_TICK,
	output logic             O_CTRL_WAKE,
	output logic             O_CTRL_WAKE_CALL,
	output logic             O_OSC_EN,
	// Controller memories
	input  wire logic [10:0] I_ROM_ADDR,
	input  wire logic        I_ROM_LOAD,
	input  wire logic [7:0]  I_ROM_LOAD_DATA,
	output logic [7:0]       O_ROM_DATA,
	input  wire logic [7:0]  I_RAM_ADDR,
	input  wire logic        I_RAM_WR,
	input  wire logic [7:0]  I_RAM_WDATA,
	output logic [7:0]       O_RAM_RDATA,
	// Keyboard and mouse pins
	input  wire logic        I_KBD_CLOCK_PIN,
	output logic             O_KBD_CLOCK_PIN,
	output logic             O_KBD_CLOCK_PIN_OE,
	input  wire logic        I_KBD_DATA_PIN,
	output logic             O_KBD_DATA_PIN,
	output logic             O_KBD_DATA_PIN_OE,
	input  wire logic        I_AUX_CLOCK_PIN,
	output logic             O_AUX_CLOCK_PIN,
	output logic             O_AUX_CLOCK_PIN_OE,
	input  wire logic        I_AUX_DATA_PIN,
	output logic             O_AUX_DATA_PIN,
	output logic             O_AUX_DATA_PIN_OE
);
	typedef enum logic [1:0] {PWR_RUN, PWR_SOFT, PWR_HARD} pwr_t;

	pwr_t        pwr;
	logic [7:0]  output_buffer;
	logic [7:0]  output_buffer_q;
	logic        input_full_flag;
	logic        output_full_flag;
	logic        command_flag;
	logic [7:0]  user_status_bits;
	logic [7:0]  port2;
	logic [7:0]  fast_port;
	logic [4:0]  reset_count;
	logic        ctrl_tick;
	logic        host_data_wr;
	logic        host_cmd_wr;
	logic        host_in_wr;
	logic        host_data_rd;
	logic        host_status_rd;
	logic        fast_ok;
	logic [7:0]  status_word;
	logic [7:0]  rom [ROM_DEPTH];
	logic [7:0]  ram [RAM_DEPTH];

	// Host decode
	assign host_data_wr   = I_HOST_WR && I_HOST_ADDR == HOST_DATA_ADDR;
	assign host_cmd_wr    = I_HOST_WR && I_HOST_ADDR == HOST_STATUS_ADDR;
	assign host_in_wr     = host_data_wr || host_cmd_wr;
	assign host_data_rd   = I_HOST_RD && I_HOST_ADDR == HOST_DATA_ADDR;
	assign host_status_rd = I_HOST_RD && I_HOST_ADDR == HOST_STATUS_ADDR;
	assign fast_ok        = I_FAST_GATE_CONFIG[FAST_CFG_EN_BIT];

	// 12 MHz controller clock enable from the system clock
	frac_tick_gen #(
		.NUM(CTRL_CLK_KHZ),
		.DEN(SYS_CLK_KHZ)
	) u_ctrl_tick (
		.i_clk   (I_CLK_SYS),
		.i_reset (I_RESET),
		.i_clk_en(I_CLK_EN),
		.o_tick  (ctrl_tick)
	);

	// Reset stretch so the controller sees 24 full periods
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			reset_count <= RESET_COUNT;
		end else if (I_CLK_EN && ctrl_tick && reset_count != 5'h00) begin
			reset_count <= reset_count - 5'h01;
		end
	end
	// Restart from address zero is the controller's reset sequence
	assign O_CTRL_RESET = reset_count != 5'h00;

	// Input buffer: host writes data or command
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			command_flag <= 1'b0;
		end else if (I_CLK_EN && host_in_wr) begin
			command_flag <= I_HOST_ADDR[ADDR_CMD_BIT];
		end
	end

	// Data registers are not reset
	always_ff @(posedge I_CLK_SYS) begin
		if (I_CLK_EN && host_in_wr) begin
			O_CTRL_INPUT_PORT <= I_HOST_WDATA;
		end
		if (I_CLK_EN && I_CTRL_DATA_WR) begin
			output_buffer <= I_CTRL_WDATA;
		end
	end

	// Set wins over clear on both full flags
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			input_full_flag <= STATUS_RESET[STAT_IBF_BIT];
		end else if (I_CLK_EN) begin
			if (host_in_wr) begin
				input_full_flag <= 1'b1;
			end else if (I_CTRL_DATA_RD) begin
				input_full_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			output_full_flag <= STATUS_RESET[STAT_OBF_BIT];
		end else if (I_CLK_EN) begin
			if (I_CTRL_DATA_WR) begin
				output_full_flag <= 1'b1;
			end else if (host_data_rd) begin
				output_full_flag <= 1'b0;
			end
		end
	end

	// User bits writable only by the controller
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			user_status_bits <= STATUS_RESET & STAT_USER_MASK;
		end else if (I_CLK_EN && I_CTRL_STATUS_WR) begin
			user_status_bits <= I_CTRL_WDATA & STAT_USER_MASK;
		end
	end

	always_comb begin
		status_word               = user_status_bits;
		status_word[STAT_OBF_BIT] = output_full_flag;
		status_word[STAT_IBF_BIT] = input_full_flag;
		status_word[STAT_CMD_BIT] = command_flag;
	end
	assign O_CTRL_STATUS = status_word;

	// Only the input-full source lives here; the timer is the controller's
	assign O_CTRL_INPUT_FULL_INTERRUPT = input_full_flag && I_CTRL_IBF_IE;

	// Controller port 2; cleared so all pins float after reset
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			port2 <= PORT2_RESET;
		end else if (I_CLK_EN && I_CTRL_PORT2_WR) begin
			port2 <= I_CTRL_WDATA;
		end
	end
	assign O_CTRL_PORT2 = port2;

	// Open drain: a set drive bit pulls the pin low
	assign O_KBD_CLOCK_PIN    = 1'b0;
	assign O_KBD_CLOCK_PIN_OE = port2[P2_KBD_CLK_BIT];
	assign O_KBD_DATA_PIN     = 1'b0;
	assign O_KBD_DATA_PIN_OE  = port2[P2_KBD_DATA_BIT];
	assign O_AUX_CLOCK_PIN    = 1'b0;
	assign O_AUX_CLOCK_PIN_OE = port2[P2_AUX_CLK_BIT];
	assign O_AUX_DATA_PIN     = 1'b0;
	assign O_AUX_DATA_PIN_OE  = port2[P2_AUX_DATA_BIT];

	// Pin sense paths
	assign O_CTRL_PORT1_SENSE = {I_AUX_DATA_PIN, I_KBD_DATA_PIN};
	assign O_CTRL_TEST_SENSE  = {I_AUX_CLOCK_PIN, I_KBD_CLOCK_PIN};

	// Gate A20 and host interrupts
	assign O_A20_GATE = port2[P2_A20_BIT];
	always_comb begin
		if (I_CTRL_EN_FLAGS) begin
			O_KBD_INTERRUPT_OUT = output_full_flag && port2[P2_KBD_INTERRUPT_OUT_BIT];
			O_AUX_INTERRUPT_OUT = !input_full_flag && port2[P2_MIRQ_BIT];
		end else begin
			O_KBD_INTERRUPT_OUT = port2[P2_KBD_INTERRUPT_OUT_BIT];
			O_AUX_INTERRUPT_OUT = port2[P2_MIRQ_BIT];
		end
	end

	// Fast gate port, accessible only when enabled
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			fast_port <= FAST_A20_RESET;
		end else if (I_CLK_EN && fast_ok && I_HOST_WR && I_HOST_ADDR == FAST_A20_ADDR) begin
			fast_port <= (FAST_A20_RESET & ~FAST_A20_WMASK)
				| (I_HOST_WDATA & FAST_A20_WMASK);
		end
	end
	assign O_ALTERNATE_GATE_OUT = fast_port[FAST_GATE_BIT];

	// Host read data, one cycle after the strobe
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			output_buffer_q <= 8'h00;
			O_HOST_RVALID   <= 1'b0;
		end else if (I_CLK_EN) begin
			O_HOST_RVALID <= 1'b0;
			if (host_data_rd) begin
				output_buffer_q <= output_buffer;
				O_HOST_RVALID   <= 1'b1;
			end else if (host_status_rd) begin
				output_buffer_q <= status_word;
				O_HOST_RVALID   <= 1'b1;
			end else if (I_HOST_RD && fast_ok && I_HOST_ADDR == FAST_A20_ADDR) begin
				output_buffer_q <= fast_port;
				O_HOST_RVALID   <= 1'b1;
			end
		end
	end
	assign O_HOST_RDATA = output_buffer_q;

	// Power modes; reset itself is the other exit
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			pwr              <= PWR_RUN;
			O_CTRL_WAKE      <= 1'b0;
			O_CTRL_WAKE_CALL <= 1'b0;
		end else if (I_CLK_EN) begin
			O_CTRL_WAKE      <= 1'b0;
			O_CTRL_WAKE_CALL <= 1'b0;
			case (pwr)
				PWR_RUN: begin
					if (I_CTRL_STOP) begin
						pwr <= PWR_HARD;
					end else if (I_CTRL_HALT) begin
						pwr <= PWR_SOFT;
					end
				end
				PWR_SOFT, PWR_HARD: begin
					if (host_in_wr) begin
						pwr              <= PWR_RUN;
						O_CTRL_WAKE      <= 1'b1;
						O_CTRL_WAKE_CALL <= I_CTRL_IBF_IE;
					end
				end
				default: begin
					pwr <= PWR_RUN;
				end
			endcase
		end
	end

	// Hard powerdown drops the oscillator; reset must cover its restart
	assign O_OSC_EN          = pwr != PWR_HARD;
	assign O_CTRL_ALU_TICK   = ctrl_tick && pwr == PWR_RUN && !O_CTRL_RESET;
	assign O_CTRL_TIMER_TICK = ctrl_tick && pwr != PWR_HARD && !O_CTRL_RESET;

	// Program store is loaded once, then only fetched
	always_ff @(posedge I_CLK_SYS) begin
		if (I_CLK_EN) begin
			if (I_ROM_LOAD) begin
				rom[I_ROM_ADDR] <= I_ROM_LOAD_DATA;
			end
			O_ROM_DATA <= rom[I_ROM_ADDR];
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_CLK_EN) begin
			if (I_RAM_WR) begin
				ram[I_RAM_ADDR] <= I_RAM_WDATA;
			end
			O_RAM_RDATA <= ram[I_RAM_ADDR];
		end
	end
endmodule // kbc_host_interface

// ---- bench/kbc_pin_model.sv ----
// Keyboard and mouse wires with pull-ups, far-side devices pulling low
module kbc_pin_model (
	// Drives
	input  wire logic [3:0] i_oe,
	input  wire logic [3:0] i_hold_low,
	// Wire levels
	output logic [3:0]      o_wire
);
	timeunit 1ns;
	timeprecision 1ns;
	// Open drain: released wire goes to pull-up level, never the last value
	assign o_wire = ~(i_oe | i_hold_low);
endmodule // kbc_pin_model

// ---- bench/kbc_host_props.sv ----
// Checker for the keyboard controller host port
module kbc_host_props (
	// Watched ports
	input wire logic       I_CLK_SYS,
	input wire logic       I_RESET,
	input wire logic       I_CLK_EN,
	input wire logic [7:0] I_HOST_ADDR,
	input wire logic       I_HOST_RD,
	input wire logic       I_HOST_WR,
	input wire logic [7:0] I_HOST_WDATA,
	input wire logic       O_HOST_RVALID,
	input wire logic [7:0] I_FAST_GATE_CONFIG,
	input wire logic       O_KBD_INTERRUPT_OUT,
	input wire logic       O_A20_GATE,
	input wire logic       I_CTRL_DATA_WR,
	input wire logic       I_CTRL_DATA_RD,
	input wire logic       I_CTRL_EN_FLAGS,
	input wire logic       I_CTRL_IBF_IE,
	input wire logic [7:0] O_CTRL_INPUT_PORT,
	input wire logic [7:0] O_CTRL_STATUS,
	input wire logic [7:0] O_CTRL_PORT2,
	input wire logic       O_CTRL_INPUT_FULL_INTERRUPT,
	input wire logic       I_CTRL_HALT,
	input wire logic       I_CTRL_STOP,
	input wire logic       O_CTRL_RESET,
	input wire logic       O_CTRL_ALU_TICK,
	input wire logic       O_CTRL_WAKE,
	input wire logic       O_CTRL_WAKE_CALL,
	input wire logic       O_OSC_EN,
	input wire logic       O_KBD_CLOCK_PIN_OE,
	input wire logic       O_KBD_DATA_PIN_OE,
	input wire logic       O_AUX_CLOCK_PIN_OE,
	input wire logic       O_AUX_DATA_PIN_OE
);
	default clocking @(posedge I_CLK_SYS); endclocking
	// Frozen state under a low enable proves nothing
	default disable iff (I_RESET || !I_CLK_EN);
	logic wr_in;
	logic [3:0] oe;
	assign wr_in = I_HOST_WR && (I_HOST_ADDR == 8'h60 || I_HOST_ADDR == 8'h64);
	assign oe = {O_AUX_DATA_PIN_OE, O_AUX_CLOCK_PIN_OE, O_KBD_DATA_PIN_OE, O_KBD_CLOCK_PIN_OE};
	sequence s_halt;
		I_CTRL_HALT && !I_CTRL_STOP && !wr_in;
	endsequence
	sequence s_idle3;
		(!wr_in && !I_CTRL_STOP) [*3];
	endsequence
	AST_A20: assert property (O_A20_GATE == O_CTRL_PORT2[1])
		else $error("gate output not following port bit");
	AST_KBD_PINS: assert property (oe[1:0] == O_CTRL_PORT2[7:6])
		else $error("keyboard pin drive wrong");
	AST_AUX_PINS: assert property (oe[3:2] == {O_CTRL_PORT2[2], O_CTRL_PORT2[3]})
		else $error("mouse pin drive wrong");
	AST_HOST_WR: assert property (wr_in |=> O_CTRL_STATUS[1] &&
		O_CTRL_STATUS[3] == $past(I_HOST_ADDR[2]) && O_CTRL_INPUT_PORT == $past(I_HOST_WDATA))
		else $error("host write effects wrong");
	AST_CTRL_RD: assert property (I_CTRL_DATA_RD && !wr_in |=> !O_CTRL_STATUS[1])
		else $error("input full not cleared");
	AST_OBF_SET: assert property (I_CTRL_DATA_WR |=> O_CTRL_STATUS[0])
		else $error("output full not set");
	AST_OBF_CLR: assert property (I_HOST_RD && I_HOST_ADDR == 8'h60 &&
		!I_CTRL_DATA_WR |=> !O_CTRL_STATUS[0] && O_HOST_RVALID)
		else $error("output full not cleared by read");
	AST_KBD_INTERRUPT_OUT: assert property (O_KBD_INTERRUPT_OUT ==
		(I_CTRL_EN_FLAGS ? O_CTRL_STATUS[0] & O_CTRL_PORT2[4] : O_CTRL_PORT2[4]))
		else $error("keyboard interrupt wrong");
	AST_IBF_IRQ: assert property (O_CTRL_INPUT_FULL_INTERRUPT ==
		(O_CTRL_STATUS[1] & I_CTRL_IBF_IE)) else $error("input interrupt wrong");
	AST_SOFT: assert property (s_halt ##1 s_idle3 |-> !O_CTRL_ALU_TICK && O_OSC_EN)
		else $error("arithmetic unit still clocked");
	AST_WAKE: assert property (s_halt ##1 wr_in |=> O_CTRL_WAKE &&
		O_CTRL_WAKE_CALL == $past(I_CTRL_IBF_IE)) else $error("wake pulse wrong");
	AST_HARD: assert property (I_CTRL_STOP |=> !O_OSC_EN)
		else $error("oscillator not stopped");
	AST_RST_LEN: assert property ($fell(I_RESET) |-> O_CTRL_RESET [*8])
		else $error("controller reset too short");
	AST_RST_PINS: assert property ($fell(I_RESET) |-> oe == 4'h0 &&
		O_CTRL_STATUS == 8'h00) else $error("reset state wrong");
	AST_FAST: assert property (I_HOST_RD && I_HOST_ADDR == 8'h92 |=>
		O_HOST_RVALID == $past(I_FAST_GATE_CONFIG[2])) else $error("fast port gating wrong");
endmodule // kbc_host_props

// ---- bench/kbc_host_interface_tb_top.sv ----
// Testbench for the keyboard controller host port
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
	$display("mismatch at %0t: %h vs %h", $time, a, b); end end
module kbc_host_interface_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic I_CLK_SYS, I_RESET, I_CLK_EN, I_HOST_RD, I_HOST_WR, I_CTRL_DATA_WR, I_CTRL_DATA_RD;
	logic I_CTRL_STATUS_WR, I_CTRL_PORT2_WR, I_CTRL_EN_FLAGS, I_CTRL_IBF_IE, I_CTRL_HALT;
	logic I_CTRL_STOP, I_ROM_LOAD, I_RAM_WR, I_KBD_CLOCK_PIN, I_KBD_DATA_PIN;
	logic I_AUX_CLOCK_PIN, I_AUX_DATA_PIN;
	logic [7:0] I_HOST_ADDR, I_HOST_WDATA, I_FAST_GATE_CONFIG, I_CTRL_WDATA, I_ROM_LOAD_DATA;
	logic [7:0] I_RAM_ADDR, I_RAM_WDATA, O_HOST_RDATA, O_CTRL_INPUT_PORT, O_CTRL_STATUS;
	logic [7:0] O_CTRL_PORT2, O_ROM_DATA, O_RAM_RDATA;
	logic [10:0] I_ROM_ADDR;
	logic [1:0] O_CTRL_PORT1_SENSE, O_CTRL_TEST_SENSE;
	logic O_HOST_RVALID, O_KBD_INTERRUPT_OUT, O_AUX_INTERRUPT_OUT, O_A20_GATE;
	logic O_ALTERNATE_GATE_OUT, O_CTRL_INPUT_FULL_INTERRUPT, O_CTRL_RESET, O_CTRL_ALU_TICK;
	logic O_CTRL_TIMER_TICK, O_CTRL_WAKE, O_CTRL_WAKE_CALL, O_OSC_EN, O_KBD_CLOCK_PIN;
	logic O_KBD_CLOCK_PIN_OE, O_KBD_DATA_PIN, O_KBD_DATA_PIN_OE, O_AUX_CLOCK_PIN;
	logic O_AUX_CLOCK_PIN_OE, O_AUX_DATA_PIN, O_AUX_DATA_PIN_OE;
	logic [3:0] hold_low, pin_wire;
	int miscompares, checked, n, a, t;
	typedef struct {logic [7:0] adr; logic [7:0] dat; logic cd;} row_t;
	row_t rows [4] = '{'{8'h60, 8'h5a, 1'b0}, '{8'h64, 8'ha5, 1'b1},
		'{8'h60, 8'h00, 1'b0}, '{8'h64, 8'hff, 1'b1}};
	logic [7:0] pbit [4] = '{8'h40, 8'h80, 8'h08, 8'h04};
	logic [3:0] psense [4] = '{4'he, 4'hb, 4'hd, 4'h7};
	localparam logic [3:0] DW = 4'h8, PW = 4'h4, SW = 4'h2, DR = 4'h1;

	kbc_host_interface i_dut (.*);
	kbc_pin_model i_pins (
		.i_oe       ({O_AUX_DATA_PIN_OE, O_AUX_CLOCK_PIN_OE, O_KBD_DATA_PIN_OE, O_KBD_CLOCK_PIN_OE}),
		.i_hold_low (hold_low),
		.o_wire     (pin_wire)
	);
	assign {I_AUX_DATA_PIN, I_AUX_CLOCK_PIN, I_KBD_DATA_PIN, I_KBD_CLOCK_PIN} = pin_wire;

	initial begin
		I_CLK_SYS = 0;
		forever #10 I_CLK_SYS = ~I_CLK_SYS;
	end

	task automatic finish_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic hw(input logic [7:0] adr, input logic [7:0] d);
		I_HOST_ADDR = adr;
		I_HOST_WDATA = d;
		I_HOST_WR = 1;
		@(negedge I_CLK_SYS);
		I_HOST_WR = 0;
	endtask

	task automatic hr(input logic [7:0] adr, input logic [7:0] e, input logic v);
		I_HOST_ADDR = adr;
		I_HOST_RD = 1;
		@(negedge I_CLK_SYS);
		I_HOST_RD = 0;
		`CHK(O_HOST_RVALID, v)
		if (v) `CHK(O_HOST_RDATA, e)
		// Idle edge so a following read never re-raises the strobe at once
		@(negedge I_CLK_SYS);
	endtask

	// One-hot strobe: data write, port write, status write, data read
	task automatic ctl(input logic [3:0] k, input logic [7:0] d);
		I_CTRL_WDATA = d;
		{I_CTRL_DATA_WR, I_CTRL_PORT2_WR, I_CTRL_STATUS_WR, I_CTRL_DATA_RD} = k;
		@(negedge I_CLK_SYS);
		{I_CTRL_DATA_WR, I_CTRL_PORT2_WR, I_CTRL_STATUS_WR, I_CTRL_DATA_RD} = 4'h0;
		@(negedge I_CLK_SYS);
	endtask

	// Controller reset stretch: 24 ticks of 12/50 is 100 system cycles
	task automatic reset_len();
		n = 0;
		while (O_CTRL_RESET === 1'b1 && n < 300) begin
			@(negedge I_CLK_SYS);
			n++;
		end
		`CHK(n > 95 && n < 300, 1'b1)
	endtask

	initial begin
		repeat (20000) @(posedge I_CLK_SYS);
		miscompares++;
		finish_test();
	end

	initial begin
		{I_HOST_RD, I_HOST_WR, I_CTRL_DATA_WR, I_CTRL_DATA_RD, I_CTRL_STATUS_WR} = '0;
		{I_CTRL_PORT2_WR, I_CTRL_EN_FLAGS, I_CTRL_HALT, I_CTRL_STOP, I_ROM_LOAD, I_RAM_WR} = '0;
		{I_HOST_ADDR, I_HOST_WDATA, I_FAST_GATE_CONFIG, I_CTRL_WDATA, I_ROM_LOAD_DATA} = '0;
		{I_RAM_ADDR, I_RAM_WDATA, I_ROM_ADDR, hold_low} = '0;
		I_CTRL_IBF_IE = 1;
		I_CLK_EN = 1;
		I_RESET = 1;
		repeat (2) @(negedge I_CLK_SYS);
		I_RESET = 0;
		`CHK(O_CTRL_STATUS, 8'h00)
		`CHK(pin_wire, 4'hf)
		reset_len();
		I_FAST_GATE_CONFIG = 8'h04;
		hr(8'h92, 8'h24, 1'b1);
		hw(8'h92, 8'hff);
		`CHK(O_ALTERNATE_GATE_OUT, 1'b1)
		hr(8'h92, 8'h27, 1'b1);
		I_FAST_GATE_CONFIG = 8'h00;
		hr(8'h92, 8'h00, 1'b0);
		hr(8'h61, 8'h00, 1'b0);
		foreach (rows[i]) begin
			hw(rows[i].adr, rows[i].dat);
			`CHK(O_CTRL_STATUS[3:1], {rows[i].cd, 2'b01})
			`CHK(O_CTRL_INPUT_FULL_INTERRUPT, 1'b1)
			ctl(DR, 8'h00);
			`CHK(O_CTRL_INPUT_PORT, rows[i].dat)
			`CHK(O_CTRL_STATUS[1], 1'b0)
		end
		I_CTRL_EN_FLAGS = 1;
		ctl(PW, 8'h32);
		`CHK(O_A20_GATE, 1'b1)
		ctl(DW, 8'h3c);
		`CHK(O_CTRL_STATUS[0], 1'b1)
		`CHK(O_KBD_INTERRUPT_OUT, 1'b1)
		`CHK(O_AUX_INTERRUPT_OUT, 1'b1)
		hr(8'h60, 8'h3c, 1'b1);
		`CHK(O_KBD_INTERRUPT_OUT, 1'b0)
		`CHK(O_CTRL_STATUS[0], 1'b0)
		ctl(SW, 8'hff);
		`CHK(O_CTRL_STATUS, 8'hfc)
		hw(8'h64, 8'h00);
		`CHK(O_AUX_INTERRUPT_OUT, 1'b0)
		hr(8'h64, 8'hfe, 1'b1);
		ctl(DR, 8'h00);
		foreach (pbit[i]) begin
			ctl(PW, pbit[i]);
			`CHK({O_CTRL_PORT1_SENSE, O_CTRL_TEST_SENSE}, psense[i])
			`CHK(O_CTRL_PORT2, pbit[i])
			`CHK({O_AUX_DATA_PIN, O_AUX_CLOCK_PIN, O_KBD_DATA_PIN, O_KBD_CLOCK_PIN}, 4'h0)
		end
		ctl(PW, 8'h00);
		hold_low = 4'h4;
		#1 `CHK(O_CTRL_TEST_SENSE, 2'b01)
		hold_low = 4'h0;
		I_CTRL_HALT = 1;
		@(negedge I_CLK_SYS);
		I_CTRL_HALT = 0;
		a = 0;
		t = 0;
		repeat (50) begin
			@(negedge I_CLK_SYS);
			a += O_CTRL_ALU_TICK;
			t += O_CTRL_TIMER_TICK;
		end
		`CHK(a, 0)
		`CHK(t > 10, 1'b1)
		hw(8'h60, 8'h77);
		`CHK(O_CTRL_WAKE, 1'b1)
		`CHK(O_CTRL_WAKE_CALL, 1'b1)
		ctl(DR, 8'h00);
		a = 0;
		repeat (50) begin
			@(negedge I_CLK_SYS);
			a += O_CTRL_ALU_TICK;
		end
		`CHK(a > 10, 1'b1)
		// Write right after halt, interrupt disabled: plain resume
		I_CTRL_IBF_IE = 0;
		I_CTRL_HALT = 1;
		@(negedge I_CLK_SYS);
		I_CTRL_HALT = 0;
		hw(8'h60, 8'h78);
		`CHK(O_CTRL_WAKE, 1'b1)
		`CHK(O_CTRL_WAKE_CALL, 1'b0)
		ctl(DR, 8'h00);
		I_CTRL_STOP = 1;
		@(negedge I_CLK_SYS);
		I_CTRL_STOP = 0;
		`CHK(O_OSC_EN, 1'b0)
		hw(8'h64, 8'h79);
		`CHK(O_OSC_EN, 1'b1)
		`CHK(O_CTRL_WAKE, 1'b1)
		ctl(DR, 8'h00);
		I_CTRL_IBF_IE = 1;
		I_CTRL_STOP = 1;
		@(negedge I_CLK_SYS);
		I_CTRL_STOP = 0;
		`CHK(O_OSC_EN, 1'b0)
		// Long reset covers the oscillator restart
		I_RESET = 1;
		repeat (100) @(negedge I_CLK_SYS);
		`CHK(O_OSC_EN, 1'b1)
		`CHK(O_CTRL_RESET, 1'b1)
		I_RESET = 0;
		reset_len();
		`CHK(O_ALTERNATE_GATE_OUT, 1'b0)
		I_RAM_ADDR = 8'hff;
		I_RAM_WDATA = 8'ha5;
		I_RAM_WR = 1;
		I_ROM_ADDR = 11'h7ff;
		I_ROM_LOAD_DATA = 8'h3c;
		I_ROM_LOAD = 1;
		@(negedge I_CLK_SYS);
		{I_RAM_WR, I_ROM_LOAD} = 2'b00;
		@(negedge I_CLK_SYS);
		`CHK(O_RAM_RDATA, 8'ha5)
		`CHK(O_ROM_DATA, 8'h3c)
		finish_test();
	end
endmodule // kbc_host_interface_tb_top

bind kbc_host_interface kbc_host_props i_props (.*);
